// File: hdl/pch_pkg.sv
// shared constants and types of the supply command handler
package pch_pkg;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_OPER = 8'h01;
  localparam logic [7:0] CMD_WG = 8'h10;
  localparam logic [7:0] CMD_RALL = 8'h12;
  localparam logic [7:0] CMD_RONE = 8'h14;
  localparam logic [7:0] CMD_SUSER = 8'h17;
  localparam logic [7:0] CMD_RUSER = 8'h18;
  localparam logic [7:0] CMD_FMT = 8'h20;
  localparam logic [7:0] CMD_SETP = 8'h21;
  localparam logic [7:0] CMD_VINON = 8'h35;
  localparam logic [7:0] CMD_VINOFF = 8'h36;
  localparam logic [7:0] CMD_FCFG = 8'h3A;
  localparam logic [7:0] CMD_FCMD = 8'h3B;
  localparam logic [7:0] CMD_OVT = 8'h40;
  localparam logic [7:0] CMD_OVA = 8'h41;
  localparam logic [7:0] CMD_OVW = 8'h42;
  localparam logic [7:0] CMD_UVW = 8'h43;
  localparam logic [7:0] CMD_UVT = 8'h44;
  localparam logic [7:0] CMD_UVA = 8'h45;
  localparam logic [7:0] CMD_OCT = 8'h46;
  localparam logic [7:0] CMD_SVOUT = 8'h7A;
  localparam logic [7:0] CMD_CML = 8'h7E;
  // ----------------------------------------
  // data codes
  // ----------------------------------------
  localparam logic [7:0] WG_ALL = 8'h00;
  localparam logic [7:0] WG_NONE = 8'h80;
  localparam logic [7:0] WG_OPER = 8'h40;
  localparam logic [7:0] OPER_ON = 8'h80;
  localparam logic [7:0] OPER_OFF = 8'h00;
  localparam logic [7:0] UVA_LATCH = 8'h80;
  localparam logic [7:0] UVA_RESTART = 8'hC0;
  localparam logic [7:0] OVA_VALUE = 8'h80;
  localparam logic [7:0] FAN_CFG_DUTY = 8'h80;
  localparam logic [7:0] FAN_MAX = 8'h64;
  localparam logic [7:0] FAN_INTERNAL = 8'h00;
  localparam logic [2:0] FMT_LINEAR = 3'h0;
  localparam logic [4:0] FMT_EXP = 5'h17;
  // ----------------------------------------
  // limits, output volts times 512, input volts and amps plain
  // ----------------------------------------
  localparam logic [15:0] V_21 = 16'h2A00;
  localparam logic [15:0] V_23 = 16'h2E00;
  localparam logic [15:0] V_25 = 16'h3200;
  localparam logic [15:0] V_30 = 16'h3C00;
  localparam logic [15:0] V_36 = 16'h4800;
  localparam logic [15:0] V_41 = 16'h5200;
  localparam logic [15:0] V_65 = 16'h8200;
  localparam logic [15:0] V_66 = 16'h8400;
  localparam logic [15:0] V_68 = 16'h8800;
  localparam logic [15:0] I_0 = 16'h0000;
  localparam logic [15:0] I_60 = 16'h003C;
  localparam logic [15:0] VIN_ON_LL = 16'h0055;
  localparam logic [15:0] VIN_OFF_LL = 16'h0050;
  localparam logic [15:0] VIN_ON_HL = 16'h00B4;
  localparam logic [15:0] VIN_OFF_HL = 16'h00AA;
  // ----------------------------------------
  // setting slots and status bits
  // ----------------------------------------
  localparam logic [3:0] IX_SETP = 4'h0;
  localparam logic [3:0] IX_FCFG = 4'h1;
  localparam logic [3:0] IX_FCMD = 4'h2;
  localparam logic [3:0] IX_OVT = 4'h3;
  localparam logic [3:0] IX_OVW = 4'h4;
  localparam logic [3:0] IX_UVW = 4'h5;
  localparam logic [3:0] IX_UVT = 4'h6;
  localparam logic [3:0] IX_UVA = 4'h7;
  localparam logic [3:0] IX_OCT = 4'h8;
  localparam logic [3:0] IX_NONE = 4'hF;
  localparam int N_SET = 9;
  localparam int CML_CMD = 7;
  localparam int CML_DATA = 6;
  localparam int SV_OVF = 7;
  localparam int SV_OVW = 6;
  localparam int SV_UVW = 5;
  localparam int SV_UVF = 4;
  // ----------------------------------------
  // link and timing
  // ----------------------------------------
  localparam logic [6:0] BUS_ADDR = 7'h58;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RETRY_S = 1;
  localparam int unsigned WINDOW_S = 60;
  localparam logic [1:0] OV_MAX_SHUT = 2'h3;
  typedef struct packed {
    logic scl;
    logic sda;
    logic enable;
    logic high_line;
    logic overload;
    logic input_lost;
    logic [15:0] vout;
    logic [15:0] vprog;
  } pch_pins_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h3, I_WBYTE = 3'h2,
    I_WACK = 3'h6, I_RBYTE = 3'h7, I_RACK = 3'h5
  } pch_i2c_t;
  typedef enum logic [1:0] {
    P_RUN = 2'h0, P_WAIT = 2'h1, P_LATCH = 2'h3
  } pch_prot_t;
endpackage

// File: hdl/pch_top.sv
// command handler of the managed supply, serial link to settings
`timescale 1ns/1ns
module pch_top
  import pch_pkg::*;
#(
  parameter int unsigned RETRY_CYC = RETRY_S * CLK_HZ,
  parameter int unsigned WINDOW_CYC = WINDOW_S * CLK_HZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // supply pins
  input wire logic enable_pin,
  input wire logic high_line,
  input wire logic overload,
  input wire logic input_lost,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] vprog_level,
  // supply controls
  output logic main_output_on,
  output logic alert_n,
  output logic [15:0] setpoint_out,
  output logic [7:0] fan_duty,
  output logic fan_override,
  output logic [15:0] oc_trip_level,
  output logic oc_trip_enable
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [3:0] slot(input logic [7:0] c);
    case (c)
      CMD_SETP: slot = IX_SETP;
      CMD_FCFG: slot = IX_FCFG;
      CMD_FCMD: slot = IX_FCMD;
      CMD_OVT: slot = IX_OVT;
      CMD_OVW: slot = IX_OVW;
      CMD_UVW: slot = IX_UVW;
      CMD_UVT: slot = IX_UVT;
      CMD_UVA: slot = IX_UVA;
      CMD_OCT: slot = IX_OCT;
      default: slot = IX_NONE;
    endcase
  endfunction
  function automatic logic [15:0] factory(input logic [3:0] i);
    case (i)
      IX_SETP: factory = V_23;
      IX_FCFG: factory = {8'h00, FAN_CFG_DUTY};
      IX_FCMD: factory = {8'h00, FAN_INTERNAL};
      IX_OVT: factory = V_68;
      IX_OVW: factory = V_66;
      IX_UVW: factory = V_41;
      IX_UVT: factory = V_36;
      IX_UVA: factory = {8'h00, UVA_RESTART};
      default: factory = I_60;
    endcase
  endfunction
  function automatic logic ok_val(input logic [3:0] i,
                                  input logic [15:0] v);
    case (i)
      IX_SETP: ok_val = v >= V_23 && v <= V_65;
      IX_FCFG: ok_val = v == {8'h00, FAN_CFG_DUTY};
      IX_FCMD: ok_val = v <= {8'h00, FAN_MAX};
      IX_OVT: ok_val = v >= V_30 && v <= V_68;
      IX_OVW: ok_val = v >= V_25 && v <= V_66;
      IX_UVW: ok_val = v >= V_21 && v <= V_65;
      IX_UVT: ok_val = v >= V_21 && v <= V_65;
      IX_UVA: ok_val = v == {8'h00, UVA_LATCH} ||
                       v == {8'h00, UVA_RESTART};
      default: ok_val = v >= I_0 && v <= I_60;
    endcase
  endfunction
  function automatic logic narrow(input logic [3:0] i);
    narrow = i == IX_FCFG || i == IX_FCMD || i == IX_UVA;
  endfunction
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_ff;
  logic rst_n;
  pch_pins_t pin_raw, pin_s1, pin_s2;
  logic scl_d, sda_d;
  assign rst_n = rst_ff[1];
  assign pin_raw = '{scl: scl_in, sda: sda_in, enable: enable_pin,
                     high_line: high_line, overload: overload,
                     input_lost: input_lost, vout: vout_meas,
                     vprog: vprog_level};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '{scl: 1'b1, sda: 1'b1, default: '0};
      pin_s2 <= '{scl: 1'b1, sda: 1'b1, default: '0};
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      scl_d <= pin_s2.scl;
      sda_d <= pin_s2.sda;
    end
  end
  // ----------------------------------------
  // serial link slave
  // ----------------------------------------
  logic start_c, stop_c, rise, fall, commit;
  pch_i2c_t ist, next_ist;
  logic [3:0] bits, next_bits;
  logic [7:0] sh, next_sh, tx, next_tx, cmd, next_cmd;
  logic [7:0] d0, next_d0, d1, next_d1, rd_byte;
  logic drv, next_drv, rw, next_rw;
  logic [1:0] nb, next_nb, rdi, next_rdi;
  logic [15:0] rd_word;
  assign start_c = pin_s2.scl && scl_d && sda_d && !pin_s2.sda;
  assign stop_c = pin_s2.scl && scl_d && !sda_d && pin_s2.sda;
  assign rise = pin_s2.scl && !scl_d;
  assign fall = !pin_s2.scl && scl_d;
  assign rd_byte = rdi == 2'h0 ? rd_word[7:0] :
                   rdi == 2'h1 ? rd_word[15:8] : 8'hFF;
  always_comb begin
    next_ist = ist;
    next_bits = bits;
    next_sh = sh;
    next_tx = tx;
    next_drv = drv;
    next_rw = rw;
    next_nb = nb;
    next_rdi = rdi;
    next_cmd = cmd;
    next_d0 = d0;
    next_d1 = d1;
    commit = 1'b0;
    if (start_c) begin
      next_ist = I_ADDR;
      next_bits = 4'h0;
      next_nb = 2'h0;
      next_rdi = 2'h0;
      next_drv = 1'b0;
    end else if (stop_c) begin
      next_ist = I_IDLE;
      next_drv = 1'b0;
      commit = !rw && nb != 2'h0;
    end else begin
      case (ist)
        I_ADDR, I_WBYTE: begin
          if (rise) begin
            next_sh = {sh[6:0], pin_s2.sda};
            next_bits = bits + 4'h1;
          end else if (fall && bits == 4'h8) begin
            next_bits = 4'h0;
            next_drv = 1'b1;
            if (ist == I_WBYTE) begin
              next_ist = I_WACK;
              next_nb = nb == 2'h3 ? nb : nb + 2'h1;
              case (nb)
                2'h0: next_cmd = sh;
                2'h1: next_d0 = sh;
                2'h2: next_d1 = sh;
                default: next_drv = 1'b1;
              endcase
            end else if (sh[7:1] == BUS_ADDR) begin
              next_ist = I_AACK;
              next_rw = sh[0];
            end else begin
              next_ist = I_IDLE;
              next_drv = 1'b0;
            end
          end
        end
        I_AACK, I_WACK, I_RACK: begin
          if (rise && ist == I_RACK) begin
            if (pin_s2.sda) begin
              next_ist = I_IDLE;
            end else begin
              next_rdi = rdi == 2'h3 ? rdi : rdi + 2'h1;
            end
          end else if (fall) begin
            next_bits = 4'h0;
            if (ist == I_WACK || !rw) begin
              next_ist = I_WBYTE;
              next_drv = 1'b0;
            end else begin
              next_ist = I_RBYTE;
              next_tx = rd_byte;
              next_drv = !rd_byte[7];
            end
          end
        end
        I_RBYTE: begin
          if (fall) begin
            if (bits == 4'h7) begin
              next_ist = I_RACK;
              next_drv = 1'b0;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_drv = !tx[6];
              next_bits = bits + 4'h1;
            end
          end
        end
        default: next_drv = 1'b0;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ist <= I_IDLE;
      bits <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      drv <= 1'b0;
      rw <= 1'b0;
      nb <= 2'h0;
      rdi <= 2'h0;
      cmd <= 8'h00;
      d0 <= 8'h00;
      d1 <= 8'h00;
    end else begin
      ist <= next_ist;
      bits <= next_bits;
      sh <= next_sh;
      tx <= next_tx;
      drv <= next_drv;
      rw <= next_rw;
      nb <= next_nb;
      rdi <= next_rdi;
      cmd <= next_cmd;
      d0 <= next_d0;
      d1 <= next_d1;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = drv;
  // ----------------------------------------
  // protection sequencer
  // ----------------------------------------
  logic [15:0] op [N_SET];
  logic [15:0] user [N_SET];
  logic [15:0] next_op [N_SET];
  logic [15:0] next_user [N_SET];
  logic cmd_on, next_cmd_on;
  pch_prot_t pst, next_pst;
  logic [1:0] shut, next_shut;
  logic [31:0] dly, next_dly, win, next_win;
  logic saw_off, next_saw_off, restart_ok, ov_now, uv_now;
  logic ovw_now, uvw_now, out_run;
  assign out_run = cmd_on && pin_s2.enable && pst == P_RUN;
  assign ov_now = out_run && pin_s2.vout > op[IX_OVT];
  assign uv_now = out_run && pin_s2.vout < op[IX_UVT] &&
                  !pin_s2.overload && !pin_s2.input_lost;
  assign ovw_now = out_run && pin_s2.vout > op[IX_OVW];
  assign uvw_now = out_run && pin_s2.vout < op[IX_UVW];
  always_comb begin
    next_pst = pst;
    next_shut = shut;
    next_dly = dly;
    next_win = win;
    next_saw_off = saw_off;
    restart_ok = 1'b0;
    if (shut != 2'h0) begin
      next_win = win + 32'h1;
      if (win >= WINDOW_CYC - 1) begin
        next_shut = 2'h0;
        next_win = 32'h0;
      end
    end
    case (pst)
      P_RUN: begin
        if (ov_now) begin
          next_dly = 32'h0;
          if (shut == OV_MAX_SHUT) begin
            next_pst = P_LATCH;
            next_saw_off = 1'b0;
          end else begin
            next_pst = P_WAIT;
            next_shut = shut + 2'h1;
            if (shut == 2'h0) begin
              next_win = 32'h0;
            end
          end
        end else if (uv_now) begin
          next_dly = 32'h0;
          next_saw_off = 1'b0;
          next_pst = op[IX_UVA][7:0] == UVA_LATCH ? P_LATCH : P_WAIT;
        end
      end
      P_WAIT: begin
        next_dly = dly + 32'h1;
        if (dly >= RETRY_CYC - 1) begin
          next_pst = P_RUN;
        end
      end
      default: begin
        if (!pin_s2.enable || !cmd_on) begin
          next_saw_off = 1'b1;
        end else if (saw_off) begin
          next_pst = P_RUN;
          next_shut = 2'h0;
          restart_ok = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pst <= P_RUN;
      shut <= 2'h0;
      dly <= 32'h0;
      win <= 32'h0;
      saw_off <= 1'b0;
    end else begin
      pst <= next_pst;
      shut <= next_shut;
      dly <= next_dly;
      win <= next_win;
      saw_off <= next_saw_off;
    end
  end
  // ----------------------------------------
  // settings and command execution
  // ----------------------------------------
  logic [7:0] wg, next_wg, cml, next_cml, sv, next_sv;
  logic sw_set, next_sw_set, allowed, next_alert_n;
  logic [3:0] ix, dx;
  logic [15:0] wval;
  assign ix = slot(cmd);
  assign dx = slot(d0);
  assign wval = narrow(ix) ? {8'h00, d0} : {d1, d0};
  assign allowed = cmd == CMD_WG || wg == WG_ALL ||
                   (wg == WG_OPER && cmd == CMD_OPER);
  always_comb begin
    rd_word = 16'hFFFF;
    case (cmd)
      CMD_WG: rd_word = {8'h00, wg};
      CMD_OPER: rd_word = {8'h00, cmd_on ? OPER_ON : OPER_OFF};
      CMD_FMT: rd_word = {8'h00, FMT_LINEAR, FMT_EXP};
      CMD_VINON: rd_word = pin_s2.high_line ? VIN_ON_HL : VIN_ON_LL;
      CMD_VINOFF: rd_word = pin_s2.high_line ? VIN_OFF_HL : VIN_OFF_LL;
      CMD_OVA: rd_word = {8'h00, OVA_VALUE};
      CMD_SVOUT: rd_word = {8'h00, sv};
      CMD_CML: rd_word = {8'h00, cml};
      default: begin
        if (ix != IX_NONE) begin
          rd_word = op[ix];
        end
      end
    endcase
  end
  always_comb begin
    next_op = op;
    next_user = user;
    next_wg = wg;
    next_cmd_on = cmd_on;
    next_sw_set = sw_set;
    next_cml = restart_ok ? 8'h00 : cml;
    next_sv = restart_ok ? 8'h00 : sv;
    next_sv[SV_OVF] = next_sv[SV_OVF] | (pst == P_RUN && ov_now);
    next_sv[SV_UVF] = next_sv[SV_UVF] | (pst == P_RUN && uv_now);
    next_sv[SV_OVW] = next_sv[SV_OVW] | ovw_now;
    next_sv[SV_UVW] = next_sv[SV_UVW] | uvw_now;
    next_alert_n = !(ovw_now || uvw_now);
    if (commit && allowed) begin
      case (cmd)
        CMD_WG: begin
          if (d0 == WG_ALL || d0 == WG_NONE || d0 == WG_OPER) begin
            next_wg = d0;
          end else begin
            next_cml[CML_DATA] = 1'b1;
          end
        end
        CMD_OPER: begin
          if (d0 == OPER_ON || d0 == OPER_OFF) begin
            next_cmd_on = d0 == OPER_ON;
          end else begin
            next_cml[CML_DATA] = 1'b1;
          end
        end
        CMD_RALL: begin
          for (int k = 0; k < N_SET; k++) begin
            next_op[k] = factory(4'(k));
          end
        end
        CMD_RONE, CMD_SUSER, CMD_RUSER: begin
          if (dx == IX_NONE) begin
            next_cml[CML_DATA] = 1'b1;
          end else if (cmd == CMD_RONE) begin
            next_op[dx] = factory(dx);
          end else if (cmd == CMD_SUSER) begin
            next_user[dx] = op[dx];
          end else begin
            next_op[dx] = user[dx];
          end
        end
        default: begin
          if (ix == IX_NONE) begin
            next_cml[CML_CMD] = 1'b1;
          end else if (ok_val(ix, wval) &&
                       (narrow(ix) || nb == 2'h3)) begin
            next_op[ix] = wval;
            next_sw_set = sw_set || ix == IX_SETP;
          end else begin
            next_cml[CML_DATA] = 1'b1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < N_SET; k++) begin
        op[k] <= factory(4'(k));
        user[k] <= factory(4'(k));
      end
      wg <= WG_ALL;
      cmd_on <= 1'b1;
      sw_set <= 1'b0;
      cml <= 8'h00;
      sv <= 8'h00;
      alert_n <= 1'b1;
      main_output_on <= 1'b0;
      setpoint_out <= 16'h0000;
      fan_duty <= 8'h00;
      fan_override <= 1'b0;
      oc_trip_level <= I_60;
      oc_trip_enable <= 1'b0;
    end else begin
      op <= next_op;
      user <= next_user;
      wg <= next_wg;
      cmd_on <= next_cmd_on;
      sw_set <= next_sw_set;
      cml <= next_cml;
      sv <= next_sv;
      alert_n <= next_alert_n;
      main_output_on <= out_run;
      setpoint_out <= sw_set ? op[IX_SETP] : pin_s2.vprog;
      fan_duty <= op[IX_FCMD][7:0];
      fan_override <= op[IX_FCMD][7:0] != FAN_INTERNAL;
      oc_trip_level <= op[IX_OCT];
      oc_trip_enable <= pin_s2.high_line;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_guard_blocks: assert property (
    commit && wg == WG_NONE && cmd == CMD_SETP |=> $stable(op[IX_SETP]))
    else $error("blocked write changed setpoint");
  a_guard_taken: assert property (
    commit && cmd == CMD_WG && d0 == WG_ALL |=> wg == WG_ALL)
    else $error("guard write not taken");
  a_guard_nostore: assert property (
    commit && allowed && cmd == CMD_SUSER && d0 == CMD_WG
    |=> cml[CML_DATA])
    else $error("guard store not refused");
  a_range_keep: assert property (
    commit && allowed && cmd == CMD_SETP && !ok_val(IX_SETP, wval)
    |=> $stable(op[IX_SETP]) && cml[CML_DATA])
    else $error("out of range setpoint accepted");
  a_pin_follow: assert property (
    !sw_set && !$past(sw_set) |=> setpoint_out == $past(pin_s2.vprog))
    else $error("setpoint not following pin");
  a_latch_off: assert property (
    pst == P_RUN && ov_now && shut == OV_MAX_SHUT |=> pst == P_LATCH)
    else $error("no latch after three shutdowns");
  a_retry_off: assert property (
    pst == P_RUN && ov_now && shut != OV_MAX_SHUT
    |=> pst == P_WAIT ##1 !main_output_on [*2])
    else $error("output on during retry delay");
  a_alert_ov: assert property (
    ovw_now |=> !alert_n)
    else $error("alert not raised on overvoltage warning");
  a_uv_action: assert property (
    op[IX_UVA][7:0] == UVA_LATCH || op[IX_UVA][7:0] == UVA_RESTART)
    else $error("illegal undervoltage action");
endmodule

// File: verification/pch_host.sv
// host model on the serial management link
`timescale 1ns/1ns
module pch_host
  import pch_pkg::*;
(
  // link
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp;
    repeat (4) @(negedge clk);
  endtask
  task automatic start;
    @(negedge clk);
    sda_low = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  task automatic stop;
    @(negedge clk);
    sda_low = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_low = 1'b0;
    hp;
  endtask
  task automatic put(input logic b);
    sda_low = ~b;
    hp;
    scl = 1'b1;
    hp;
    scl = 1'b0;
  endtask
  task automatic get(output logic b);
    sda_low = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    b = sda;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = ~a;
  endtask
  task automatic write(input logic [7:0] c, input int n,
                       input logic [15:0] d, output logic ack);
    logic a;
    start;
    wbyte({BUS_ADDR, 1'b0}, ack);
    wbyte(c, a);
    if (n > 0) wbyte(d[7:0], a);
    if (n > 1) wbyte(d[15:8], a);
    stop;
  endtask
  task automatic read(input logic [7:0] c, output logic [15:0] d);
    logic a;
    start;
    wbyte({BUS_ADDR, 1'b0}, a);
    wbyte(c, a);
    start;
    wbyte({BUS_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b0);
    for (int i = 15; i >= 8; i--) get(d[i]);
    put(1'b1);
    stop;
  endtask
endmodule

// File: verification/tb_pch_top.sv
// self-checking bench of the supply command handler
`timescale 1ns/1ns
module tb_pch_top import pch_pkg::*;;
  logic ref_clk = 1'b0, reset_n = 1'b0, enable_pin = 1'b1;
  logic high_line = 1'b0, scl, sda_low, sda_oe, ack, overload = 1'b0;
  logic main_output_on, alert_n, fan_override, oc_trip_enable;
  logic [15:0] vout_meas = 16'h6000, vprog_level = 16'h3000, rd;
  logic [15:0] setpoint_out, oc_trip_level;
  logic [7:0] fan_duty;
  wire sda_line;
  int error_cnt = 0, tests_run = 0;
  assign sda_line = ~(sda_oe | sda_low);
  always #25 ref_clk = ~ref_clk;
  pch_top #(.RETRY_CYC(20), .WINDOW_CYC(400)) i_dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe(sda_oe), .enable_pin(enable_pin), .high_line(high_line),
    .overload(overload), .input_lost(1'b0), .vout_meas(vout_meas),
    .vprog_level(vprog_level), .main_output_on(main_output_on),
    .alert_n(alert_n), .setpoint_out(setpoint_out), .fan_duty(fan_duty),
    .fan_override(fan_override), .oc_trip_level(oc_trip_level),
    .oc_trip_enable(oc_trip_enable));
  pch_host i_host (.clk(ref_clk), .sda(sda_line), .scl(scl),
    .sda_low(sda_low));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
    i_host.write(c, n, d, ack);
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] c, input logic [15:0] e, input bit w);
    i_host.read(c, rd);
    check(w ? rd : {8'h00, rd[7:0]}, e);
  endtask
  task automatic t_reset;
    rc(CMD_WG, 16'h0000, 0);
    rc(CMD_FMT, {8'h00, FMT_LINEAR, FMT_EXP}, 0);
    rc(CMD_SETP, V_23, 1);
    rc(CMD_UVA, 16'(UVA_RESTART), 0);
    rc(CMD_OCT, I_60, 1);
    rc(CMD_UVW, V_41, 1);
    rc(CMD_FCFG, 16'(FAN_CFG_DUTY), 0);
    rc(CMD_CML, 16'h0000, 0);
  endtask
  task automatic t_setp;
    check(setpoint_out, 16'h3000);
    wr(CMD_SETP, 2, V_65);
    check(setpoint_out, V_65);
    vprog_level = 16'h3800;
    repeat (8) @(negedge ref_clk);
    check(setpoint_out, V_65);
    wr(CMD_SETP, 2, V_66);
    rc(CMD_SETP, V_65, 1);
    rc(CMD_CML, 16'h0040, 0);
  endtask
  task automatic t_guard;
    wr(CMD_WG, 1, 16'(WG_NONE));
    wr(CMD_FCMD, 1, 16'h0032);
    check(16'(fan_duty), 16'h0000);
    wr(CMD_OPER, 1, 16'(OPER_OFF));
    check(16'(main_output_on), 16'h0001);
    rc(CMD_WG, 16'(WG_NONE), 0);
    wr(CMD_WG, 1, 16'(WG_OPER));
    wr(CMD_FCMD, 1, 16'h0032);
    check(16'(fan_duty), 16'h0000);
    wr(CMD_OPER, 1, 16'(OPER_OFF));
    check(16'(main_output_on), 16'h0000);
    wr(CMD_OPER, 1, 16'(OPER_ON));
    check(16'(main_output_on), 16'h0001);
    wr(CMD_WG, 1, 16'(WG_ALL));
  endtask
  task automatic t_fan;
    wr(CMD_FCMD, 1, 16'h0064);
    check(16'({fan_override, fan_duty}), 16'h0164);
    wr(CMD_FCMD, 1, 16'h0065);
    check(16'({fan_override, fan_duty}), 16'h0164);
    wr(CMD_FCMD, 1, 16'h0000);
    check(16'({fan_override, fan_duty}), 16'h0000);
  endtask
  task automatic t_store;
    wr(CMD_SUSER, 1, {8'h00, CMD_SETP});
    wr(CMD_OCT, 2, 16'h0020);
    wr(CMD_UVA, 1, 16'h0090);
    rc(CMD_UVA, 16'(UVA_RESTART), 0);
    wr(CMD_UVA, 1, 16'(UVA_LATCH));
    rc(CMD_UVA, 16'(UVA_LATCH), 0);
    wr(CMD_RONE, 1, {8'h00, CMD_SETP});
    rc(CMD_SETP, V_23, 1);
    rc(CMD_OCT, 16'h0020, 1);
    wr(CMD_RUSER, 1, {8'h00, CMD_SETP});
    rc(CMD_SETP, V_65, 1);
    wr(CMD_RALL, 0, 16'h0000);
    rc(CMD_OCT, I_60, 1);
    rc(CMD_UVA, 16'(UVA_RESTART), 0);
  endtask
  task automatic t_pins;
    high_line = 1'b1;
    rc(CMD_VINON, VIN_ON_HL, 1);
    check(16'(oc_trip_enable), 16'h0001);
    high_line = 1'b0;
    rc(CMD_VINOFF, VIN_OFF_LL, 1);
    vout_meas = V_66 + 16'h0001;
    repeat (8) @(negedge ref_clk);
    check(16'(alert_n), 16'h0000);
    vout_meas = 16'h5100;
    repeat (8) @(negedge ref_clk);
    check(16'(alert_n), 16'h0000);
    vout_meas = 16'h6000;
    repeat (8) @(negedge ref_clk);
    check(16'(alert_n), 16'h0001);
  endtask
  task automatic t_prot;
    vout_meas = V_68 + 16'h0001;
    repeat (200) @(negedge ref_clk);
    check(16'(main_output_on), 16'h0000);
    rc(CMD_SVOUT, 16'h00E0, 0);
    vout_meas = 16'h6000;
    repeat (40) @(negedge ref_clk);
    check(16'(main_output_on), 16'h0000);
    enable_pin = 1'b0;
    repeat (8) @(negedge ref_clk);
    enable_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    check(16'(main_output_on), 16'h0001);
    rc(CMD_SVOUT, 16'h0000, 0);
    overload = 1'b1;
    vout_meas = 16'h4000;
    repeat (40) @(negedge ref_clk);
    check(16'(main_output_on), 16'h0001);
    overload = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(16'(main_output_on), 16'h0000);
    vout_meas = 16'h6000;
    repeat (40) @(negedge ref_clk);
    check(16'(main_output_on), 16'h0001);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_reset;
    t_setp;
    t_guard;
    t_fan;
    t_store;
    t_pins;
    t_prot;
    conclude;
  end
  initial begin
    #4_000_000;
    error_cnt++;
    conclude;
  end
endmodule
